// ---- cpu_regs_pkg.sv ----
`default_nettype none
package cpu_regs_pkg;
	localparam int          DATA_W         = 8;
	localparam int          ADDR_W         = 16;
	localparam logic [15:0] MODE_ADDR      = 16'h003B;
	localparam int          STACK_PAGE_BIT = 2;
	localparam int          BREAK_BIT      = 4;
	localparam logic [7:0]  PAGE0_HIGH     = 8'h00;
	localparam logic [7:0]  PAGE1_HIGH     = 8'h01;
	localparam logic [7:0]  BYTE_ONE       = 8'h01;
	localparam logic [15:0] WORD_ONE       = 16'h0001;
	localparam logic [7:0]  BYTE_ZERO      = 8'h00;
	localparam logic [15:0] WORD_ZERO      = 16'h0000;
	localparam logic [7:0]  ACC_RESET      = 8'h00;
	localparam logic [7:0]  INDEX_RESET    = 8'h00;
	localparam logic [7:0]  SP_RESET       = 8'hFF;
	localparam logic [7:0]  STATUS_RESET   = 8'h04;
	localparam logic [7:0]  MODE_RESET     = 8'h00;
	localparam logic [15:0] IP_RESET       = 16'h0000;

	typedef enum logic [4:0] {
		no_op,
		load_accumulator_op,
		load_index_x_op,
		load_index_y_op,
		load_stack_op,
		load_status_op,
		index_x_op,
		index_y_op,
		store_op,
		push_accumulator_op,
		pop_accumulator_op,
		push_status_op,
		pop_status_op,
		break_op,
		jump_op,
		step_op,
		fast_set_op,
		slow_set_op,
		oscillator_halt_op,
		wait_op,
		product_op,
		divide_op
	} cmd_t;

	typedef enum logic [1:0] {
		IDLE,
		POP_READ,
		POP_CAPTURE
	} pop_state_t;
endpackage
`default_nettype wire

// ---- index_adder.sv ----
`timescale 1ns/1ns
`default_nettype none
module index_adder #(
	parameter int ADDR_W = 16,
	parameter int DATA_W = 8
) (
	input  wire logic [ADDR_W-1:0] base,
	input  wire logic [DATA_W-1:0] index,
	output logic      [ADDR_W-1:0] sum
);
	// operand plus zero-extended index register
	assign sum = base + ADDR_W'(index);
endmodule
`default_nettype wire

// ---- cpu_register_stack_addressing.sv ----
// What this block does
// - an 8-bit accumulator is the main source and target of data moves.
// - indexed by the first index register, the address is operand plus it.
// - indexed by the second index register, the address is operand plus it.
// - the 8-bit stack pointer gives the low byte of every stack address.
// - the stack address high byte is 00 with page bit clear, 01 with it set.
// - a 16-bit instruction pointer of high and low bytes holds next address.
// - accumulator and status each have a push and a matching pop.
// - fast-set and slow-set commands are not supported and are refused.
// - oscillator halt, wait, multiply and divide are supported.
// - the stack page bit lives in the mode register at address 0x3B.
// - a break pushes status with break bit set; the live bit reads zero.
`timescale 1ns/1ns
`default_nettype none
module cpu_register_stack_addressing #(
	parameter int DATA_W = cpu_regs_pkg::DATA_W,
	parameter int ADDR_W = cpu_regs_pkg::ADDR_W
) (
	input  wire logic                 core_clk,
	input  wire logic                 rst_b,
	input  wire logic                 cmdValid,
	input  wire cpu_regs_pkg::cmd_t   cmd,
	input  wire logic [DATA_W-1:0]    cmdData,
	input  wire logic [ADDR_W-1:0]    cmdAddr,
	input  wire logic [DATA_W-1:0]    memRdata,
	output logic                      busy,
	output logic [DATA_W-1:0]         accumulator,
	output logic [DATA_W-1:0]         indexX,
	output logic [DATA_W-1:0]         indexY,
	output logic [DATA_W-1:0]         stackPointer,
	output logic [DATA_W-1:0]         statusReg,
	output logic [DATA_W-1:0]         processorModeRegister,
	output logic [ADDR_W-1:0]         instructionPointer,
	output logic [ADDR_W-1:0]         effAddr,
	output logic [ADDR_W-1:0]         memAddr,
	output logic [DATA_W-1:0]         memWdata,
	output logic                      memWrite,
	output logic                      memRead,
	output logic                      illegalOp,
	output logic                      haltReq,
	output logic                      waitReq
);
	logic rstSync1;
	logic rstSync2;
	logic rstN;

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rstSync1 <= 1'b0;
			rstSync2 <= 1'b0;
		end
		else
		begin
			rstSync1 <= 1'b1;
			rstSync2 <= rstSync1;
		end
	end
	assign rstN = rstSync2;

	function automatic logic [ADDR_W-1:0] stackAddr(
		input logic [DATA_W-1:0] mode,
		input logic [DATA_W-1:0] sp
	);
		stackAddr = {mode[cpu_regs_pkg::STACK_PAGE_BIT] ?
			cpu_regs_pkg::PAGE1_HIGH : cpu_regs_pkg::PAGE0_HIGH, sp};
	endfunction

	logic [ADDR_W-1:0] sumX;
	logic [ADDR_W-1:0] sumY;

	index_adder #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) addX (
		.base (cmdAddr),
		.index(indexX),
		.sum  (sumX)
	);
	index_adder #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) addY (
		.base (cmdAddr),
		.index(indexY),
		.sum  (sumY)
	);

	cpu_regs_pkg::pop_state_t popState;
	cpu_regs_pkg::pop_state_t next_popState;
	logic                     popToStatus;
	logic                     next_popToStatus;
	logic [DATA_W-1:0]        ipHigh;
	logic [DATA_W-1:0]        ipLow;
	logic [DATA_W-1:0]        next_ipHigh;
	logic [DATA_W-1:0]        next_ipLow;
	logic [DATA_W-1:0]        next_accumulator;
	logic [DATA_W-1:0]        next_indexX;
	logic [DATA_W-1:0]        next_indexY;
	logic [DATA_W-1:0]        next_stackPointer;
	logic [DATA_W-1:0]        next_statusReg;
	logic [DATA_W-1:0]        next_mode;
	logic [ADDR_W-1:0]        next_effAddr;
	logic [ADDR_W-1:0]        next_memAddr;
	logic [DATA_W-1:0]        next_memWdata;
	logic                     next_memWrite;
	logic                     next_memRead;
	logic                     next_illegalOp;
	logic                     next_haltReq;
	logic                     next_waitReq;
	logic                     take;
	logic [ADDR_W-1:0]        product;
	logic [ADDR_W-1:0]        dividend;
	logic [ADDR_W-1:0]        quotient;
	logic [ADDR_W-1:0]        remainder;

	assign take      = cmdValid && popState == cpu_regs_pkg::IDLE;
	assign product   = ADDR_W'(accumulator) * ADDR_W'(cmdData);
	assign dividend  = {indexY, accumulator};
	assign quotient  = (cmdData == cpu_regs_pkg::BYTE_ZERO) ?
		cpu_regs_pkg::WORD_ZERO : dividend / ADDR_W'(cmdData);
	assign remainder = (cmdData == cpu_regs_pkg::BYTE_ZERO) ?
		cpu_regs_pkg::WORD_ZERO : dividend % ADDR_W'(cmdData);

	always_comb
	begin
		next_popState     = popState;
		next_popToStatus  = popToStatus;
		next_accumulator  = accumulator;
		next_indexX       = indexX;
		next_indexY       = indexY;
		next_stackPointer = stackPointer;
		next_statusReg    = statusReg;
		next_mode         = processorModeRegister;
		next_ipHigh       = ipHigh;
		next_ipLow        = ipLow;
		next_effAddr      = effAddr;
		next_memAddr      = memAddr;
		next_memWdata     = memWdata;
		next_memWrite     = 1'b0;
		next_memRead      = 1'b0;
		next_illegalOp    = 1'b0;
		next_haltReq      = 1'b0;
		next_waitReq      = 1'b0;
		unique case (popState)
			cpu_regs_pkg::IDLE:
			begin
				if (take)
				begin
					unique case (cmd)
						cpu_regs_pkg::no_op:
						begin
						end
						cpu_regs_pkg::load_accumulator_op:
							next_accumulator = cmdData;
						cpu_regs_pkg::load_index_x_op:
							next_indexX = cmdData;
						cpu_regs_pkg::load_index_y_op:
							next_indexY = cmdData;
						cpu_regs_pkg::load_stack_op:
							next_stackPointer = cmdData;
						cpu_regs_pkg::load_status_op:
						begin
							next_statusReg = cmdData;
							next_statusReg[cpu_regs_pkg::BREAK_BIT] = 1'b0;
						end
						cpu_regs_pkg::index_x_op:
							next_effAddr = sumX;
						cpu_regs_pkg::index_y_op:
							next_effAddr = sumY;
						cpu_regs_pkg::store_op:
						begin
							next_memAddr  = cmdAddr;
							next_memWdata = accumulator;
							next_memWrite = 1'b1;
							if (cmdAddr == cpu_regs_pkg::MODE_ADDR)
								next_mode = accumulator;
						end
						cpu_regs_pkg::push_accumulator_op,
						cpu_regs_pkg::push_status_op,
						cpu_regs_pkg::break_op:
						begin
							next_memAddr  = stackAddr(processorModeRegister,
								stackPointer);
							next_memWrite = 1'b1;
							next_stackPointer = stackPointer -
								cpu_regs_pkg::BYTE_ONE;
							if (cmd == cpu_regs_pkg::push_accumulator_op)
								next_memWdata = accumulator;
							else
								next_memWdata = statusReg;
							if (cmd == cpu_regs_pkg::break_op)
								next_memWdata[cpu_regs_pkg::BREAK_BIT] = 1'b1;
						end
						cpu_regs_pkg::pop_accumulator_op,
						cpu_regs_pkg::pop_status_op:
						begin
							next_stackPointer = stackPointer +
								cpu_regs_pkg::BYTE_ONE;
							next_memAddr = stackAddr(processorModeRegister,
								next_stackPointer);
							next_memRead = 1'b1;
							next_popToStatus = cmd == cpu_regs_pkg::pop_status_op;
							next_popState = cpu_regs_pkg::POP_READ;
						end
						cpu_regs_pkg::jump_op:
							{next_ipHigh, next_ipLow} = cmdAddr;
						cpu_regs_pkg::step_op:
							{next_ipHigh, next_ipLow} = {ipHigh, ipLow} +
								cpu_regs_pkg::WORD_ONE;
						cpu_regs_pkg::fast_set_op,
						cpu_regs_pkg::slow_set_op:
							next_illegalOp = 1'b1;
						cpu_regs_pkg::oscillator_halt_op:
							next_haltReq = 1'b1;
						cpu_regs_pkg::wait_op:
							next_waitReq = 1'b1;
						cpu_regs_pkg::product_op:
							{next_indexY, next_accumulator} = product;
						cpu_regs_pkg::divide_op:
						begin
							next_illegalOp = cmdData == cpu_regs_pkg::BYTE_ZERO;
							next_accumulator = quotient[DATA_W-1:0];
							next_indexY = remainder[DATA_W-1:0];
						end
						default:
							next_illegalOp = 1'b1;
					endcase
				end
			end
			cpu_regs_pkg::POP_READ:
				next_popState = cpu_regs_pkg::POP_CAPTURE;
			cpu_regs_pkg::POP_CAPTURE:
			begin
				next_popState = cpu_regs_pkg::IDLE;
				if (popToStatus)
				begin
					next_statusReg = memRdata;
					next_statusReg[cpu_regs_pkg::BREAK_BIT] = 1'b0;
				end
				else
					next_accumulator = memRdata;
			end
			default:
				next_popState = cpu_regs_pkg::IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			popState              <= cpu_regs_pkg::IDLE;
			popToStatus           <= 1'b0;
			busy                  <= 1'b0;
			accumulator           <= cpu_regs_pkg::ACC_RESET;
			indexX                <= cpu_regs_pkg::INDEX_RESET;
			indexY                <= cpu_regs_pkg::INDEX_RESET;
			stackPointer          <= cpu_regs_pkg::SP_RESET;
			statusReg             <= cpu_regs_pkg::STATUS_RESET;
			processorModeRegister <= cpu_regs_pkg::MODE_RESET;
			ipHigh                <= cpu_regs_pkg::IP_RESET[15:8];
			ipLow                 <= cpu_regs_pkg::IP_RESET[7:0];
			instructionPointer    <= cpu_regs_pkg::IP_RESET;
			effAddr               <= cpu_regs_pkg::WORD_ZERO;
			memAddr               <= cpu_regs_pkg::WORD_ZERO;
			memWdata              <= cpu_regs_pkg::BYTE_ZERO;
			memWrite              <= 1'b0;
			memRead               <= 1'b0;
			illegalOp             <= 1'b0;
			haltReq               <= 1'b0;
			waitReq               <= 1'b0;
		end
		else
		begin
			popState              <= next_popState;
			popToStatus           <= next_popToStatus;
			busy                  <= next_popState != cpu_regs_pkg::IDLE;
			accumulator           <= next_accumulator;
			indexX                <= next_indexX;
			indexY                <= next_indexY;
			stackPointer          <= next_stackPointer;
			statusReg             <= next_statusReg;
			processorModeRegister <= next_mode;
			ipHigh                <= next_ipHigh;
			ipLow                 <= next_ipLow;
			instructionPointer    <= {next_ipHigh, next_ipLow};
			effAddr               <= next_effAddr;
			memAddr               <= next_memAddr;
			memWdata              <= next_memWdata;
			memWrite              <= next_memWrite;
			memRead               <= next_memRead;
			illegalOp             <= next_illegalOp;
			haltReq               <= next_haltReq;
			waitReq               <= next_waitReq;
		end
	end

	property p_push_acc;
		@(posedge core_clk) disable iff (!rstN)
		take && cmd == cpu_regs_pkg::push_accumulator_op |=>
			memWrite && memWdata == $past(accumulator) &&
			memAddr[7:0] == $past(stackPointer) &&
			stackPointer == $past(stackPointer) - 8'h01;
	endproperty
	a_push_acc: assert property (p_push_acc)
		else $error("push did not write then decrement");

	property p_page;
		@(posedge core_clk) disable iff (!rstN)
		memWrite && $past(take && (cmd == cpu_regs_pkg::push_status_op ||
			cmd == cpu_regs_pkg::push_accumulator_op ||
			cmd == cpu_regs_pkg::break_op)) |->
			memAddr[15:8] == ($past(processorModeRegister[
			cpu_regs_pkg::STACK_PAGE_BIT]) ?
			cpu_regs_pkg::PAGE1_HIGH : cpu_regs_pkg::PAGE0_HIGH);
	endproperty
	a_page: assert property (p_page)
		else $error("stack page high byte wrong");

	property p_pop;
		@(posedge core_clk) disable iff (!rstN)
		take && cmd == cpu_regs_pkg::pop_accumulator_op |=>
			memRead && memAddr[7:0] == $past(stackPointer) + 8'h01
			##1 busy ##1 accumulator == $past(memRdata) && !busy;
	endproperty
	a_pop: assert property (p_pop)
		else $error("pop sequence wrong");

	property p_break;
		@(posedge core_clk) disable iff (!rstN)
		take && cmd == cpu_regs_pkg::break_op |=> memWrite &&
			memWdata[cpu_regs_pkg::BREAK_BIT];
	endproperty
	a_break: assert property (p_break)
		else $error("break image lacks break bit");

	property p_live_break;
		@(posedge core_clk) disable iff (!rstN)
		!statusReg[cpu_regs_pkg::BREAK_BIT];
	endproperty
	a_live_break: assert property (p_live_break)
		else $error("live break bit set");

	property p_index_x;
		@(posedge core_clk) disable iff (!rstN)
		take && cmd == cpu_regs_pkg::index_x_op |=>
			effAddr == $past(cmdAddr) + {8'h00, $past(indexX)};
	endproperty
	a_index_x: assert property (p_index_x)
		else $error("x indexed address wrong");

	property p_index_y;
		@(posedge core_clk) disable iff (!rstN)
		take && cmd == cpu_regs_pkg::index_y_op |=>
			effAddr == $past(cmdAddr) + {8'h00, $past(indexY)};
	endproperty
	a_index_y: assert property (p_index_y)
		else $error("y indexed address wrong");

	property p_step;
		@(posedge core_clk) disable iff (!rstN)
		take && cmd == cpu_regs_pkg::step_op |=>
			instructionPointer == $past(instructionPointer) + 16'h0001;
	endproperty
	a_step: assert property (p_step)
		else $error("pointer step wrong");

	property p_refuse;
		@(posedge core_clk) disable iff (!rstN)
		take && (cmd == cpu_regs_pkg::fast_set_op ||
			cmd == cpu_regs_pkg::slow_set_op) |=> illegalOp && !memWrite &&
			accumulator == $past(accumulator) &&
			stackPointer == $past(stackPointer)
			##1 (!illegalOp ||
			$past(take && (cmd == cpu_regs_pkg::fast_set_op ||
			cmd == cpu_regs_pkg::slow_set_op ||
			(cmd == cpu_regs_pkg::divide_op &&
			cmdData == cpu_regs_pkg::BYTE_ZERO))));
	endproperty
	a_refuse: assert property (p_refuse)
		else $error("unsupported command not refused");

	property p_mode;
		@(posedge core_clk) disable iff (!rstN)
		take && cmd == cpu_regs_pkg::store_op &&
			cmdAddr == cpu_regs_pkg::MODE_ADDR |=>
			processorModeRegister == $past(accumulator);
	endproperty
	a_mode: assert property (p_mode)
		else $error("mode register not written");

	property p_product;
		@(posedge core_clk) disable iff (!rstN)
		take && cmd == cpu_regs_pkg::product_op |=>
			{indexY, accumulator} == $past(accumulator) * $past(cmdData);
	endproperty
	a_product: assert property (p_product)
		else $error("product wrong");
endmodule
`default_nettype wire

// ---- cpu_register_stack_addressing_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module cpu_register_stack_addressing_bench;
	typedef struct {
		logic [4:0]  kind;
		logic [15:0] addr;
		logic [7:0]  data;
	} note_t;
	localparam logic [4:0] K_WR = 5'h10;
	localparam logic [4:0] K_RD = 5'h08;
	localparam logic [4:0] K_ILL = 5'h04;
	localparam logic [4:0] K_HALT = 5'h02;
	localparam logic [4:0] K_WAIT = 5'h01;
	logic                 core_clk;
	logic                 rst_b;
	logic                 cmdValid;
	cpu_regs_pkg::cmd_t   cmd;
	logic [7:0]           cmdData;
	logic [15:0]          cmdAddr;
	logic [7:0]           memRdata;
	logic                 busy;
	logic [7:0]           accumulator;
	logic [7:0]           indexX;
	logic [7:0]           indexY;
	logic [7:0]           stackPointer;
	logic [7:0]           statusReg;
	logic [7:0]           processorModeRegister;
	logic [15:0]          instructionPointer;
	logic [15:0]          effAddr;
	logic [15:0]          memAddr;
	logic [7:0]           memWdata;
	logic                 memWrite;
	logic                 memRead;
	logic                 illegalOp;
	logic                 haltReq;
	logic                 waitReq;
	logic [7:0]           eA, eX, eY, eSP, eS, eM;
	logic [15:0]          eIP, eEff;
	note_t                notes[$];
	note_t                seen;
	int                   n_errors = 0;
	int                   checks = 0;

	cpu_register_stack_addressing u_cpu_register_stack_addressing (
		.core_clk(core_clk), .rst_b(rst_b), .cmdValid(cmdValid), .cmd(cmd),
		.cmdData(cmdData), .cmdAddr(cmdAddr), .memRdata(memRdata),
		.busy(busy), .accumulator(accumulator), .indexX(indexX),
		.indexY(indexY), .stackPointer(stackPointer), .statusReg(statusReg),
		.processorModeRegister(processorModeRegister),
		.instructionPointer(instructionPointer), .effAddr(effAddr),
		.memAddr(memAddr), .memWdata(memWdata), .memWrite(memWrite),
		.memRead(memRead), .illegalOp(illegalOp), .haltReq(haltReq),
		.waitReq(waitReq)
	);

	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic check(input logic [15:0] s, input logic [15:0] e,
		input string w);
		checks++;
		if (s !== e)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h",
				$time, w, s, e);
		end
	endtask

	task final_report;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	function automatic logic [7:0] rb();
		logic [31:0] r;
		r = $urandom;
		return r[7:0];
	endfunction

	function automatic logic [7:0] hi();
		return eM[cpu_regs_pkg::STACK_PAGE_BIT] ?
			cpu_regs_pkg::PAGE1_HIGH : cpu_regs_pkg::PAGE0_HIGH;
	endfunction

	task automatic note(input logic [4:0] k, input logic [15:0] a,
		input logic [7:0] d);
		notes.push_back('{k, a, d});
	endtask

	// present one command and update the expected model
	task automatic op(input cpu_regs_pkg::cmd_t c, input logic [7:0] d,
		input logic [15:0] a);
		logic [15:0] q;
		logic [15:0] r;
		@(posedge core_clk);
		cmdValid <= 1'b1;
		cmd <= c;
		cmdData <= d;
		cmdAddr <= a;
		case (c)
			cpu_regs_pkg::load_accumulator_op: eA = d;
			cpu_regs_pkg::load_index_x_op: eX = d;
			cpu_regs_pkg::load_index_y_op: eY = d;
			cpu_regs_pkg::load_stack_op: eSP = d;
			cpu_regs_pkg::load_status_op: eS = d & 8'hEF;
			cpu_regs_pkg::index_x_op: eEff = a + {8'h00, eX};
			cpu_regs_pkg::index_y_op: eEff = a + {8'h00, eY};
			cpu_regs_pkg::store_op:
			begin
				note(K_WR, a, eA);
				if (a == cpu_regs_pkg::MODE_ADDR)
					eM = eA;
			end
			cpu_regs_pkg::push_accumulator_op:
			begin
				note(K_WR, {hi(), eSP}, eA);
				eSP = eSP - 8'h01;
			end
			cpu_regs_pkg::push_status_op:
			begin
				note(K_WR, {hi(), eSP}, eS);
				eSP = eSP - 8'h01;
			end
			cpu_regs_pkg::break_op:
			begin
				note(K_WR, {hi(), eSP}, eS | 8'h10);
				eSP = eSP - 8'h01;
			end
			cpu_regs_pkg::jump_op: eIP = a;
			cpu_regs_pkg::step_op: eIP = eIP + 16'h0001;
			cpu_regs_pkg::fast_set_op, cpu_regs_pkg::slow_set_op:
				note(K_ILL, 16'h0000, 8'h00);
			cpu_regs_pkg::oscillator_halt_op: note(K_HALT, 16'h0000, 8'h00);
			cpu_regs_pkg::wait_op: note(K_WAIT, 16'h0000, 8'h00);
			cpu_regs_pkg::product_op: {eY, eA} = {8'h00, eA} * {8'h00, d};
			cpu_regs_pkg::divide_op:
			begin
				if (d == 8'h00)
				begin
					note(K_ILL, 16'h0000, 8'h00);
					eA = 8'h00;
					eY = 8'h00;
				end
				else
				begin
					q = {eY, eA} / {8'h00, d};
					r = {eY, eA} % {8'h00, d};
					eA = q[7:0];
					eY = r[7:0];
				end
			end
			default: ;
		endcase
	endtask

	task automatic check_regs;
		check({8'h00, accumulator}, {8'h00, eA}, "acc");
		check({8'h00, indexX}, {8'h00, eX}, "index x");
		check({8'h00, indexY}, {8'h00, eY}, "index y");
		check({8'h00, stackPointer}, {8'h00, eSP}, "stack ptr");
		check({8'h00, statusReg}, {8'h00, eS}, "status");
		check({8'h00, processorModeRegister}, {8'h00, eM}, "mode");
		check(instructionPointer, eIP, "ip");
		check(effAddr, eEff, "eff addr");
		check({15'h0000, busy}, 16'h0000, "busy");
	endtask

	task automatic idle;
		@(posedge core_clk);
		cmdValid <= 1'b0;
		cmd <= cpu_regs_pkg::no_op;
		#1;
		check_regs();
	endtask

	// pop with a step offered while busy, which is ignored, not flagged
	task automatic pop(input cpu_regs_pkg::cmd_t c, input logic [7:0] v);
		eSP = eSP + 8'h01;
		note(K_RD, {hi(), eSP}, 8'h00);
		op(c, 8'h00, 16'h0000);
		@(posedge core_clk);
		cmd <= cpu_regs_pkg::step_op;
		memRdata <= v;
		repeat (2) @(posedge core_clk);
		cmdValid <= 1'b0;
		memRdata <= ~v;
		#1;
		if (c == cpu_regs_pkg::pop_accumulator_op)
			eA = v;
		else
			eS = v & 8'hEF;
		check_regs();
	endtask

	always @(negedge core_clk)
	begin
		if (memWrite || memRead || illegalOp || haltReq || waitReq)
		begin
			if (notes.size() == 0)
				check(16'h0001, 16'h0000, "unexpected pulse");
			else
			begin
				seen = notes.pop_front();
				check({11'h000, memWrite, memRead, illegalOp,
					haltReq, waitReq}, {11'h000, seen.kind},
					"pulse kind");
				if (memWrite || memRead)
					check(memAddr, seen.addr, "stack addr");
				if (memWrite)
					check({8'h00, memWdata}, {8'h00, seen.data},
						"write data");
			end
		end
	end

	initial
	begin
		#100000;
		n_errors++;
		final_report();
	end

	initial
	begin
		rst_b = 1'b0;
		cmdValid = 1'b0;
		cmd = cpu_regs_pkg::no_op;
		cmdData = 8'h00;
		cmdAddr = 16'h0000;
		memRdata = 8'h00;
		{eA, eX, eY, eM} = 32'h00000000;
		eSP = 8'hFF;
		eS = 8'h04;
		eIP = 16'h0000;
		eEff = 16'h0000;
		void'($urandom(31));
		repeat (3) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
		check_regs();
		op(cpu_regs_pkg::load_accumulator_op, rb(), 16'h0000);
		op(cpu_regs_pkg::load_index_x_op, rb() | 8'h80, 16'h0000);
		op(cpu_regs_pkg::load_index_y_op, rb(), 16'h0000);
		idle();
		for (int i = 0; i < 4; i++)
		begin
			op(cpu_regs_pkg::index_x_op, 8'h00, {rb(), rb()});
			idle();
			op(cpu_regs_pkg::index_y_op, 8'h00, {rb(), rb()});
			idle();
		end
		op(cpu_regs_pkg::index_x_op, 8'h00, 16'hFFFF);
		idle();
		// software saves the accumulator itself before reusing the stack
		op(cpu_regs_pkg::push_accumulator_op, 8'h00, 16'h0000);
		op(cpu_regs_pkg::load_status_op, 8'hDF, 16'h0000);
		op(cpu_regs_pkg::push_status_op, 8'h00, 16'h0000);
		op(cpu_regs_pkg::break_op, 8'h00, 16'h0000);
		idle();
		op(cpu_regs_pkg::load_stack_op, 8'h00, 16'h0000);
		op(cpu_regs_pkg::push_accumulator_op, 8'h00, 16'h0000);
		idle();
		pop(cpu_regs_pkg::pop_accumulator_op, rb());
		pop(cpu_regs_pkg::pop_status_op, 8'hFF);
		op(cpu_regs_pkg::load_accumulator_op, 8'h04, 16'h0000);
		op(cpu_regs_pkg::store_op, 8'h00, 16'h1234);
		op(cpu_regs_pkg::store_op, 8'h00, cpu_regs_pkg::MODE_ADDR);
		op(cpu_regs_pkg::push_accumulator_op, 8'h00, 16'h0000);
		idle();
		op(cpu_regs_pkg::load_stack_op, 8'hFF, 16'h0000);
		idle();
		pop(cpu_regs_pkg::pop_accumulator_op, rb());
		op(cpu_regs_pkg::jump_op, 8'h00, 16'h12FF);
		op(cpu_regs_pkg::step_op, 8'h00, 16'h0000);
		op(cpu_regs_pkg::fast_set_op, rb(), 16'h0000);
		op(cpu_regs_pkg::slow_set_op, rb(), 16'h0000);
		op(cpu_regs_pkg::oscillator_halt_op, 8'h00, 16'h0000);
		op(cpu_regs_pkg::wait_op, 8'h00, 16'h0000);
		idle();
		op(cpu_regs_pkg::load_accumulator_op, rb(), 16'h0000);
		op(cpu_regs_pkg::product_op, rb(), 16'h0000);
		idle();
		check({indexY, accumulator}, {eY, eA}, "product");
		op(cpu_regs_pkg::load_index_y_op, 8'h00, 16'h0000);
		op(cpu_regs_pkg::divide_op, rb() | 8'h01, 16'h0000);
		idle();
		check({indexY, accumulator}, {eY, eA}, "divide");
		op(cpu_regs_pkg::divide_op, 8'h00, 16'h0000);
		idle();
		repeat (3) @(posedge core_clk);
		check(16'(notes.size()), 16'h0000, "notes left");
		final_report();
	end
endmodule
`default_nettype wire
